/* verilog/hqp_pkg.sv */
package hqp_pkg;
  // ---------------------------------------------------------------
  // queue geometry
  // ---------------------------------------------------------------
  localparam int          PTR_W          = 16;
  localparam int          QID_W          = 16;
  localparam logic [16:0] IO_MAX_ENTRIES = 17'h10000;
  localparam logic [16:0] ADM_MAX_ENTRIES = 17'h01000;
  localparam logic [16:0] MIN_ENTRIES    = 17'h00002;
  localparam int          ENTRY_BYTES    = 64;
  localparam int          ENTRY_DWORDS   = ENTRY_BYTES / 4;
  // ---------------------------------------------------------------
  // command dword 0 layout
  // ---------------------------------------------------------------
  localparam int TAG_LSB  = 16;
  localparam int TAG_W    = 16;
  localparam int PAIR_LSB = 8;
  localparam int PAIR_W   = 2;
  localparam int OPC_LSB  = 0;
  localparam int OPC_W    = 8;
  localparam int RSV_LSB  = 10;
  localparam int RSV_W    = 6;
  localparam logic [1:0] PAIR_NORMAL = 2'h0;
  localparam logic [1:0] PAIR_FIRST  = 2'h1;
  localparam logic [1:0] PAIR_SECOND = 2'h2;
  localparam logic [1:0] PAIR_RSVD   = 2'h3;
  // ---------------------------------------------------------------
  // priority classes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HQP_PRIO_URGENT = 2'b00,
    HQP_PRIO_HIGH   = 2'b01,
    HQP_PRIO_MEDIUM = 2'b10,
    HQP_PRIO_LOW    = 2'b11
  } hqp_prio_t;
  // ---------------------------------------------------------------
  // lifecycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HQP_ST_IDLE   = 2'b00,
    HQP_ST_CQ_UP  = 2'b01,
    HQP_ST_BOTH   = 2'b10
  } hqp_state_t;
  // errors reported on the user port
  localparam logic [2:0] ERR_NONE      = 3'h0;
  localparam logic [2:0] ERR_ORDER     = 3'h1;
  localparam logic [2:0] ERR_SIZE      = 3'h2;
  localparam logic [2:0] ERR_FULL      = 3'h3;
  localparam logic [2:0] ERR_NOT_IDLE  = 3'h4;
  localparam logic [2:0] ERR_PAIR_RSVD = 3'h5;
endpackage : hqp_pkg

/* verilog/hqp_skid.sv */
`timescale 1ns/1ps
module hqp_skid #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rd;
    logic [1:0]        cnt;
  } hqp_skid_t;
  hqp_skid_t s, next_s;
  logic push, pop;
  assign in_ready  = (s.cnt != 2'h2);
  assign out_valid = (s.cnt != 2'h0);
  assign out_data  = s.mem[s.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.rd ^ (s.cnt == 2'h1)] = in_data;
    end
    if (pop) begin
      next_s.rd = ~s.rd;
    end
    next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  a_skid_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data))) else $error("skid buffer lost a stalled word");
endmodule : hqp_skid

/* verilog/hqp_host_queue.sv */
`timescale 1ns/1ps
// Functional notes
// - submitter writes at tail, then advances
// - tail wraps to zero past last slot
// - consumer reads head, advances, wraps
// - submit only while queue not full
// - consume only while queue not empty
// - empty when head equals tail
// - full when head equals tail plus one
// - create completion queue before submission queue
// - delete submission queue before completion queue
// - delete submission queue only when idle
// - size field is zero-based sixteen bits
// - every queue holds at least two entries
// - io max 64K, admin max 4K
// - each queue has sixteen-bit identifier; code stores one for the submission queue only
// - each submission entry is 64 bytes
// - dword 0: tag, pairing code, opcode
// - pairing code 00 normal,01 first,10 second
module hqp_host_queue
  import hqp_pkg::*;
#(
  parameter logic [15:0] MAX_ENTRIES_SUPPORTED = 16'hFFFF,
  parameter bit          ADMIN                 = 1'b0
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // lifecycle orders
  input  wire logic                      create_cq,
  input  wire logic                      create_sq,
  input  wire logic                      delete_sq,
  input  wire logic                      delete_cq,
  input  wire logic [hqp_pkg::PTR_W-1:0] size_zb,
  input  wire logic [hqp_pkg::QID_W-1:0] queue_id,
  input  wire hqp_pkg::hqp_prio_t        prio_in,
  output logic                           order_done,
  output logic [2:0]                     order_err,
  output hqp_pkg::hqp_state_t            life_state,
  output logic [hqp_pkg::QID_W-1:0]      sq_id,
  output hqp_pkg::hqp_prio_t             sq_prio,
  // command submission from user
  input  wire logic                      cmd_valid,
  output logic                           cmd_ready,
  input  wire logic [hqp_pkg::TAG_W-1:0] command_tag,
  input  wire logic [1:0]                pairing_code,
  input  wire logic [hqp_pkg::OPC_W-1:0] operation_code,
  // submission memory write and tail doorbell toward device
  output logic                           sq_wr,
  output logic [hqp_pkg::PTR_W-1:0]      sq_wr_slot,
  output logic [31:0]                    sq_wr_dword0,
  output logic                           sq_tail_db_wr,
  output logic [hqp_pkg::PTR_W-1:0]      submission_tail_value,
  // completion entries posted by device (pin inputs)
  input  wire logic                      cpl_post,
  input  wire logic [hqp_pkg::TAG_W-1:0] cpl_tag,
  // completion head doorbell toward device
  output logic                           cq_head_db_wr,
  output logic [hqp_pkg::PTR_W-1:0]      completion_head_value,
  // completions delivered to user
  output logic                           done_valid,
  input  wire logic                      done_ready,
  output logic [hqp_pkg::TAG_W-1:0]      done_tag,
  // status
  output logic                           sq_full,
  output logic                           sq_empty,
  output logic                           cq_empty,
  output logic [hqp_pkg::PTR_W:0]        outstanding
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    hqp_state_t         life;
    logic [PTR_W-1:0]   qsize;
    logic [QID_W-1:0]   id;
    hqp_prio_t          prio;
    logic [PTR_W-1:0]   sq_tail;
    logic [PTR_W-1:0]   sq_head;
    logic [PTR_W-1:0]   cq_tail;
    logic [PTR_W-1:0]   cq_head;
    logic [PTR_W:0]     outst;
    logic               wr;
    logic [PTR_W-1:0]   wr_slot;
    logic [31:0]        dw0;
    logic               sq_db;
    logic               cq_db;
    logic               odone;
    logic [2:0]         oerr;
    logic [TAG_W-1:0]   ctag;
  } hqp_host_t;
  hqp_host_t s, next_s;
  logic [1:0]          post_sync;
  logic [TAG_W-1:0]    tag_s1, tag_s2;
  logic                post_prev;
  logic                post_evt;
  logic                buf_in_ready;
  logic [PTR_W-1:0]    sq_tail_inc, cq_head_inc, cq_tail_inc;
  logic [16:0]         entries;
  logic [16:0]         limit;
  logic                size_ok;
  logic                accept;
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      post_sync <= 2'h0;
      tag_s1    <= '0;
      tag_s2    <= '0;
      post_prev <= 1'b0;
    end else begin
      post_sync <= {post_sync[0], cpl_post};
      tag_s1    <= cpl_tag;
      tag_s2    <= tag_s1;
      post_prev <= post_sync[1];
    end
  end
  assign post_evt = post_sync[1] && !post_prev;
  // ---------------------------------------------------------------
  // pointer arithmetic
  // ---------------------------------------------------------------
  function automatic logic [PTR_W-1:0] wrap_inc(input logic [PTR_W-1:0] p, input logic [PTR_W-1:0] last);
    wrap_inc = (p == last) ? '0 : p + 16'h0001;
  endfunction : wrap_inc
  assign sq_tail_inc = wrap_inc(s.sq_tail, s.qsize);
  assign cq_head_inc = wrap_inc(s.cq_head, s.qsize);
  assign cq_tail_inc = wrap_inc(s.cq_tail, s.qsize);
  assign sq_empty    = (s.sq_head == s.sq_tail);
  assign sq_full     = (sq_tail_inc == s.sq_head);
  assign cq_empty    = (s.cq_head == s.cq_tail);
  assign entries     = {1'b0, size_zb} + 17'h00001;
  assign limit       = ADMIN ? ADM_MAX_ENTRIES
                             : ((IO_MAX_ENTRIES < ({1'b0, MAX_ENTRIES_SUPPORTED} + 17'h00001))
                                ? IO_MAX_ENTRIES : ({1'b0, MAX_ENTRIES_SUPPORTED} + 17'h00001));
  assign size_ok     = (entries >= MIN_ENTRIES) && (entries <= limit);
  assign cmd_ready   = (s.life == HQP_ST_BOTH) && !sq_full && !s.wr;
  assign accept      = cmd_valid && cmd_ready;
  // ---------------------------------------------------------------
  // main update
  // ---------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.wr    = 1'b0;
    next_s.sq_db = 1'b0;
    next_s.cq_db = 1'b0;
    next_s.odone = 1'b0;
    if (create_cq) begin
      next_s.odone = 1'b1;
      if (s.life != HQP_ST_IDLE) begin
        next_s.oerr = ERR_ORDER;
      end else if (!size_ok) begin
        next_s.oerr = ERR_SIZE;
      end else begin
        next_s.oerr    = ERR_NONE;
        next_s.life    = HQP_ST_CQ_UP;
        next_s.qsize   = size_zb;
        next_s.cq_head = '0;
        next_s.cq_tail = '0;
      end
    end else if (create_sq) begin
      next_s.odone = 1'b1;
      if (s.life != HQP_ST_CQ_UP) begin
        next_s.oerr = ERR_ORDER;
      end else if (size_zb != s.qsize) begin
        next_s.oerr = ERR_SIZE;
      end else begin
        next_s.oerr    = ERR_NONE;
        next_s.life    = HQP_ST_BOTH;
        next_s.id      = queue_id;
        next_s.prio    = prio_in;
        next_s.sq_tail = '0;
        next_s.sq_head = '0;
        next_s.outst   = '0;
      end
    end else if (delete_sq) begin
      next_s.odone = 1'b1;
      if (s.life != HQP_ST_BOTH) begin
        next_s.oerr = ERR_ORDER;
      end else if (s.outst != '0) begin
        next_s.oerr = ERR_NOT_IDLE;
      end else begin
        next_s.oerr = ERR_NONE;
        next_s.life = HQP_ST_CQ_UP;
      end
    end else if (delete_cq) begin
      next_s.odone = 1'b1;
      if (s.life != HQP_ST_CQ_UP) begin
        next_s.oerr = ERR_ORDER;
      end else begin
        next_s.oerr = ERR_NONE;
        next_s.life = HQP_ST_IDLE;
      end
    end else if (cmd_valid && (s.life == HQP_ST_BOTH) && sq_full) begin
      next_s.odone = 1'b1;
      next_s.oerr  = ERR_FULL;
    end
    if (accept && !(create_cq || create_sq || delete_sq || delete_cq)) begin
      if (pairing_code == PAIR_RSVD) begin
        next_s.odone = 1'b1;
        next_s.oerr  = ERR_PAIR_RSVD;
      end else begin
        next_s.wr      = 1'b1;
        next_s.wr_slot = s.sq_tail;
        next_s.dw0     = {command_tag, {RSV_W{1'b0}}, pairing_code, operation_code};
        next_s.sq_tail = sq_tail_inc;
        next_s.sq_db   = 1'b1;
        next_s.outst   = s.outst + 17'h00001;
      end
    end
    if (post_evt && (s.life != HQP_ST_IDLE) && (cq_tail_inc != s.cq_head)) begin
      next_s.cq_tail = cq_tail_inc;
      // only the newest posted tag is held; a second post overwrites it whether or not the buffer has taken the first
      next_s.ctag    = tag_s2;
    end
    if (!cq_empty && buf_in_ready) begin
      next_s.cq_head = cq_head_inc;
      next_s.cq_db   = 1'b1;
      if (s.outst != '0) begin
        next_s.outst   = next_s.outst - 17'h00001;
        next_s.sq_head = wrap_inc(s.sq_head, s.qsize);
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // ---------------------------------------------------------------
  // completion path buffer
  // ---------------------------------------------------------------
  hqp_skid #(.W(TAG_W)) u_done (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (!cq_empty),
    .in_ready  (buf_in_ready),
    .in_data   (s.ctag),
    .out_valid (done_valid),
    .out_ready (done_ready),
    .out_data  (done_tag)
  );
  assign order_done            = s.odone;
  assign order_err             = s.oerr;
  assign life_state            = s.life;
  assign sq_id                 = s.id;
  assign sq_prio               = s.prio;
  assign sq_wr                 = s.wr;
  assign sq_wr_slot            = s.wr_slot;
  assign sq_wr_dword0          = s.dw0;
  assign sq_tail_db_wr         = s.sq_db;
  assign submission_tail_value = s.sq_tail;
  assign cq_head_db_wr         = s.cq_db;
  assign completion_head_value = s.cq_head;
  assign outstanding           = s.outst;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_tail_wraps: assert property (@(posedge clock) disable iff (!rst_n)
    (accept && pairing_code != PAIR_RSVD && s.sq_tail == s.qsize && !create_cq && !create_sq && !delete_sq
     && !delete_cq) |=> (s.sq_tail == '0)) else $error("tail did not wrap");
  a_write_at_tail: assert property (@(posedge clock) disable iff (!rst_n)
    s.wr |-> (s.sq_tail == wrap_inc(s.wr_slot, s.qsize)) && s.sq_db) else $error("write slot not behind tail");
  a_no_submit_full: assert property (@(posedge clock) disable iff (!rst_n)
    sq_full |-> !cmd_ready && (s.outst == {1'b0, s.qsize})) else $error("submit while full");
  a_empty_count: assert property (@(posedge clock) disable iff (!rst_n)
    sq_empty |-> (s.outst == '0)) else $error("empty queue with entries outstanding");
  a_no_consume_empty: assert property (@(posedge clock) disable iff (!rst_n)
    cq_empty |=> $stable(s.cq_head)) else $error("head moved on empty");
  a_head_wraps: assert property (@(posedge clock) disable iff (!rst_n)
    (!cq_empty && buf_in_ready && s.cq_head == s.qsize) |=> (s.cq_head == '0)) else $error("head did not wrap");
  a_cq_first: assert property (@(posedge clock) disable iff (!rst_n)
    (create_sq && !create_cq && s.life == HQP_ST_IDLE) |=> (s.life == HQP_ST_IDLE && s.oerr == ERR_ORDER))
    else $error("sq created without cq");
  a_sq_del_first: assert property (@(posedge clock) disable iff (!rst_n)
    (delete_cq && !create_cq && !create_sq && !delete_sq && s.life == HQP_ST_BOTH) |=> (s.life == HQP_ST_BOTH))
    else $error("cq deleted under sq");
  a_sq_del_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (delete_sq && !create_cq && !create_sq && s.life == HQP_ST_BOTH && s.outst != '0)
    |=> (s.life == HQP_ST_BOTH && s.oerr == ERR_NOT_IDLE)) else $error("busy sq deleted");
  a_size_limit: assert property (@(posedge clock) disable iff (!rst_n)
    (s.life != HQP_ST_IDLE) |-> (s.qsize != '0) && (({1'b0, s.qsize} + 17'h00001) <= limit))
    else $error("queue size out of range");
  a_dw0_layout: assert property (@(posedge clock) disable iff (!rst_n)
    s.wr |-> (s.dw0[RSV_LSB +: RSV_W] == '0) && (s.dw0[PAIR_LSB +: PAIR_W] != PAIR_RSVD))
    else $error("dword 0 malformed");
  a_rsvd_rejected: assert property (@(posedge clock) disable iff (!rst_n)
    (accept && pairing_code == PAIR_RSVD && !create_cq && !create_sq && !delete_sq && !delete_cq)
    |=> !s.wr && s.oerr == ERR_PAIR_RSVD) else $error("reserved pairing code issued");
  c_submit: cover property (@(posedge clock) disable iff (!rst_n) s.wr);
  c_stall: cover property (@(posedge clock) disable iff (!rst_n) !cq_empty && !buf_in_ready);
  c_full: cover property (@(posedge clock) disable iff (!rst_n) sq_full);
  c_wrap: cover property (@(posedge clock) disable iff (!rst_n) s.wr && s.sq_tail == '0);
  c_done: cover property (@(posedge clock) disable iff (!rst_n) done_valid && !done_ready);
endmodule : hqp_host_queue

/* verif/hqp_dev_model.sv */
`timescale 1ns/1ps
module hqp_dev_model
  import hqp_pkg::*;
#(
  parameter int QN = 4
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // stall order from bench
  input  wire logic        hold,
  // host side writes
  input  wire logic        sq_wr,
  input  wire logic [15:0] sq_wr_slot,
  input  wire logic [31:0] sq_wr_dword0,
  input  wire logic        sq_tail_db_wr,
  input  wire logic [15:0] submission_tail_value,
  input  wire logic        cq_head_db_wr,
  input  wire logic [15:0] completion_head_value,
  // completion pins
  output logic             cpl_post,
  output logic [15:0]      cpl_tag
);
  logic [15:0] mem [QN];
  logic [15:0] sq_t;
  logic [15:0] sq_h;
  logic [15:0] cq_t;
  logic [15:0] cq_h;
  logic [3:0]  phase;
  logic        bad_db;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sq_t     <= 16'h0000;
      sq_h     <= 16'h0000;
      cq_t     <= 16'h0000;
      cq_h     <= 16'h0000;
      phase    <= 4'h0;
      bad_db   <= 1'b0;
      cpl_post <= 1'b0;
      cpl_tag  <= 16'h0000;
    end else begin
      if (sq_wr) begin
        mem[sq_wr_slot % QN] <= sq_wr_dword0[TAG_LSB +: TAG_W];
      end
      if (sq_tail_db_wr) begin
        sq_t <= submission_tail_value;
        if (submission_tail_value >= 16'(QN)) bad_db <= 1'b1;
      end
      if (cq_head_db_wr) begin
        cq_h <= completion_head_value;
      end
      // tag stands five cycles before the post pulse and three cycles after it, then is scrambled
      if (phase != 4'h0) begin
        phase <= phase - 4'h1;
        if (phase == 4'h8) cpl_post <= 1'b1;
        if (phase == 4'h4) cpl_post <= 1'b0;
        if (phase == 4'h1) cpl_tag <= ~cpl_tag;
      end else if (!hold && !bad_db && sq_h != sq_t && 16'((cq_t + 16'h0001) % QN) != cq_h) begin
        cpl_tag <= mem[sq_h % QN];
        sq_h    <= 16'((sq_h + 16'h0001) % QN);
        cq_t    <= 16'((cq_t + 16'h0001) % QN);
        phase   <= 4'hC;
      end
    end
  end
endmodule : hqp_dev_model

/* verif/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb;
  import hqp_pkg::*;
  typedef struct {
    logic [15:0] tg;
    logic [1:0]  pc;
    logic [7:0]  op;
    logic [31:0] dw;
  } hqp_row_t;
  logic clock, rst_n, create_cq, create_sq, delete_sq, delete_cq, order_done, sq_full, sq_empty, cq_empty;
  logic cmd_valid, cmd_ready, sq_wr, sq_tail_db_wr, cpl_post, cq_head_db_wr, done_valid, done_ready, hold;
  logic [15:0] size_zb, queue_id, sq_id, command_tag, sq_wr_slot, submission_tail_value, cpl_tag;
  logic [15:0] completion_head_value, done_tag, slot_e;
  logic [2:0]  order_err;
  logic [1:0]  pairing_code;
  logic [7:0]  operation_code;
  logic [31:0] sq_wr_dword0;
  logic [16:0] outstanding;
  hqp_prio_t   prio_in, sq_prio;
  hqp_state_t  life_state;
  int          fail_count, num_checks, cycles;
  hqp_row_t    rows [6] = '{'{16'h1111, 2'h0, 8'h01, 32'h11110001}, '{16'hA5C3, 2'h1, 8'h7F, 32'hA5C3017F},
                            '{16'h0000, 2'h2, 8'hFF, 32'h000002FF}, '{16'hFFFF, 2'h0, 8'h80, 32'hFFFF0080},
                            '{16'h5A5A, 2'h1, 8'h02, 32'h5A5A0102}, '{16'h00C0, 2'h2, 8'h10, 32'h00C00210}};
  hqp_host_queue #(.MAX_ENTRIES_SUPPORTED(16'h0007), .ADMIN(1'b0)) hqp_host_queue_inst (
    .clock(clock), .rst_n(rst_n), .create_cq(create_cq), .create_sq(create_sq), .delete_sq(delete_sq),
    .delete_cq(delete_cq), .size_zb(size_zb), .queue_id(queue_id), .prio_in(prio_in), .order_done(order_done),
    .order_err(order_err), .life_state(life_state), .sq_id(sq_id), .sq_prio(sq_prio), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .command_tag(command_tag), .pairing_code(pairing_code),
    .operation_code(operation_code), .sq_wr(sq_wr), .sq_wr_slot(sq_wr_slot), .sq_wr_dword0(sq_wr_dword0),
    .sq_tail_db_wr(sq_tail_db_wr), .submission_tail_value(submission_tail_value), .cpl_post(cpl_post),
    .cpl_tag(cpl_tag), .cq_head_db_wr(cq_head_db_wr), .completion_head_value(completion_head_value),
    .done_valid(done_valid), .done_ready(done_ready), .done_tag(done_tag), .sq_full(sq_full),
    .sq_empty(sq_empty), .cq_empty(cq_empty), .outstanding(outstanding));
  hqp_dev_model #(.QN(4)) hqp_dev_model_inst (
    .clock(clock), .rst_n(rst_n), .hold(hold), .sq_wr(sq_wr), .sq_wr_slot(sq_wr_slot),
    .sq_wr_dword0(sq_wr_dword0), .sq_tail_db_wr(sq_tail_db_wr), .submission_tail_value(submission_tail_value),
    .cq_head_db_wr(cq_head_db_wr), .completion_head_value(completion_head_value), .cpl_post(cpl_post),
    .cpl_tag(cpl_tag));
  // ---------------------------------------------------------------
  // clock, watchdog and verdict
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    cycles++;
    if (cycles >= 5000) begin
      fail_count++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // shared drivers
  // ---------------------------------------------------------------
  task automatic order(input int kind, input logic [15:0] sz, input logic [2:0] err, input hqp_state_t st);
    int k;
    @(negedge clock);
    create_cq = (kind == 0);
    create_sq = (kind == 1);
    delete_sq = (kind == 2);
    delete_cq = (kind == 3);
    size_zb   = sz;
    @(negedge clock);
    {create_cq, create_sq, delete_sq, delete_cq} = 4'h0;
    for (k = 0; k < 4 && order_done !== 1'b1; k++) @(negedge clock);
    `CHK("order_done", 1'b1, order_done)
    @(negedge clock);
    `CHK("order_err", err, order_err)
    `CHK("life_state", st, life_state)
  endtask : order
  task automatic submit(input hqp_row_t r, input bit wr);
    int k;
    @(negedge clock);
    cmd_valid      = 1'b1;
    command_tag    = r.tg;
    pairing_code   = r.pc;
    operation_code = r.op;
    for (k = 0; k < 20 && cmd_ready !== 1'b1; k++) @(negedge clock);
    @(negedge clock);
    cmd_valid = 1'b0;
    for (k = 0; k < 4 && sq_wr !== 1'b1; k++) @(negedge clock);
    `CHK("sq_wr", wr, sq_wr)
    if (wr) begin
      `CHK("sq_wr_dword0", r.dw, sq_wr_dword0)
      `CHK("sq_wr_slot", slot_e, sq_wr_slot)
      `CHK("sq_tail_db_wr", 1'b1, sq_tail_db_wr)
      slot_e = (slot_e + 16'h0001) % 16'h0004;
      `CHK("submission_tail_value", slot_e, submission_tail_value)
    end else begin
      `CHK("order_err", ERR_PAIR_RSVD, order_err)
    end
  endtask : submit
  task automatic wait_done(input logic [15:0] tg, input bit db);
    int k;
    for (k = 0; k < 60 && done_valid !== 1'b1; k++) @(negedge clock);
    `CHK("done_tag", tg, done_tag)
    `CHK("cq_head_db_wr", db, cq_head_db_wr)
    @(negedge clock);
  endtask : wait_done
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {create_cq, create_sq, delete_sq, delete_cq, cmd_valid, hold} = 6'h00;
    done_ready     = 1'b1;
    size_zb        = 16'h0000;
    queue_id       = 16'h00A5;
    prio_in        = HQP_PRIO_HIGH;
    command_tag    = 16'h0000;
    pairing_code   = 2'h0;
    operation_code = 8'h00;
    slot_e         = 16'h0000;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK("life_state", HQP_ST_IDLE, life_state)
    `CHK("cmd_ready", 1'b0, cmd_ready)
    `CHK("outstanding", 17'h00000, outstanding)
    order(1, 16'h0003, ERR_ORDER, HQP_ST_IDLE);
    order(0, 16'h0000, ERR_SIZE, HQP_ST_IDLE);
    order(0, 16'h0008, ERR_SIZE, HQP_ST_IDLE);
    order(0, 16'h0003, ERR_NONE, HQP_ST_CQ_UP);
    order(1, 16'h0003, ERR_NONE, HQP_ST_BOTH);
    `CHK("sq_id", 16'h00A5, sq_id)
    `CHK("sq_prio", HQP_PRIO_HIGH, sq_prio)
    order(3, 16'h0003, ERR_ORDER, HQP_ST_BOTH);
    for (int i = 0; i < 6; i++) begin
      submit(rows[i], 1'b1);
      wait_done(rows[i].tg, 1'b1);
      `CHK("completion_head_value", 16'((i + 1) % 4), completion_head_value)
    end
    submit('{16'h7777, 2'h3, 8'h05, 32'h77770305}, 1'b0);
    hold = 1'b1;
    for (int i = 0; i < 3; i++) begin
      submit(rows[i], 1'b1);
    end
    @(negedge clock);
    `CHK("sq_full", 1'b1, sq_full)
    `CHK("outstanding", 17'h00003, outstanding)
    `CHK("cmd_ready", 1'b0, cmd_ready)
    cmd_valid = 1'b1;
    repeat (3) @(negedge clock);
    cmd_valid = 1'b0;
    `CHK("order_err", ERR_FULL, order_err)
    `CHK("sq_wr", 1'b0, sq_wr)
    order(2, 16'h0003, ERR_NOT_IDLE, HQP_ST_BOTH);
    hold       = 1'b0;
    done_ready = 1'b0;
    repeat (80) @(negedge clock);
    done_ready = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wait_done(rows[i].tg, i == 2);
    end
    repeat (10) @(negedge clock);
    `CHK("sq_empty", 1'b1, sq_empty)
    `CHK("cq_empty", 1'b1, cq_empty)
    `CHK("outstanding", 17'h00000, outstanding)
    `CHK("completion_head_value", 16'h0001, completion_head_value)
    order(2, 16'h0003, ERR_NONE, HQP_ST_CQ_UP);
    order(3, 16'h0003, ERR_NONE, HQP_ST_IDLE);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK("submission_tail_value", 16'h0000, submission_tail_value)
    `CHK("completion_head_value", 16'h0000, completion_head_value)
    `CHK("life_state", HQP_ST_IDLE, life_state)
    stop_test();
  end
endmodule : tb
